/* File: hw/port_data_regs.sv */
// port b..h data registers and strong drive enable register
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module port_data_regs
   import port_data_pkg::*;
(
   input  wire logic                      ref_clk,
   input  wire logic                      sys_rst,
   input  wire logic [ADDR_W-1:0]         reg_addr,
   input  wire logic [7:0]                reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output var  logic [7:0]                reg_rdata,
   input  wire logic [NUM_PORTS-1:0][7:0] pin_output_enable,
   input  wire logic [NUM_PORTS-1:0][7:0] pin_input_enable,
   input  wire logic [NUM_PORTS-1:0][7:0] analog_enable,
   input  wire logic [NUM_PORTS-1:0][7:0] pin_in,
   output var  logic [NUM_PORTS-1:0][7:0] pin_out,
   output var  logic [NUM_PORTS-1:0][7:0] pin_oe,
   output var  logic [7:0]                strong_drive_on
);

   // ************************************************************
   // state and wires
   // ************************************************************
   typedef struct packed {
      logic [7:0] rdata;
      logic [7:0] strong_drive_select;
   } regs_state_t;

   regs_state_t                 st_r;
   regs_state_t                 st_nxt;
   logic                        port_hit;
   logic                        strong_hit;
   logic [2:0]                  lane_sel;
   logic [NUM_PORTS-1:0][7:0]   lane_rd;
   logic [7:0]                  strong_pin_out;

   // ************************************************************
   // address decode
   // ************************************************************
   assign port_hit   = (reg_addr >= PORT_B_DATA_OFS)
                       && (reg_addr <= PORT_H_DATA_OFS);
   assign strong_hit = (reg_addr == HIGH_DRIVE_ENABLE_OFS);
   assign lane_sel   = 3'(reg_addr - PORT_B_DATA_OFS);

   // ************************************************************
   // port lanes
   // ************************************************************
   for (genvar p = 0; p < NUM_PORTS; p++)
   begin : g_lane
      lane_if lane_bus ();

      // every lane sees the write data; only the addressed one latches
      assign lane_bus.wr     = reg_wr && port_hit && (lane_sel == 3'(p));
      assign lane_bus.wdata  = reg_wdata;
      assign lane_bus.oe     = pin_output_enable[p];
      assign lane_bus.ie     = pin_input_enable[p];
      assign lane_bus.ana    = analog_enable[p];
      assign lane_bus.pin_in = pin_in[p];
      assign pin_out[p]      = lane_bus.pin_out;
      assign pin_oe[p]       = lane_bus.pin_oe;
      assign lane_rd[p]      = lane_bus.rd_value;

      port_lane #(
         .IMPL    (PORT_BITS[p])
      ) u_lane (
         .ref_clk (ref_clk),
         .sys_rst (sys_rst),
         .lane    (lane_bus)
      );
   end

   // ************************************************************
   // register file
   // ************************************************************
   always_comb
   begin
      st_nxt                     = st_r;
      // read data live one cycle only, zero otherwise
      st_nxt.rdata               = 8'h00;
      if (reg_rd)
      begin
         if (port_hit)
            st_nxt.rdata = lane_rd[lane_sel];
         else if (strong_hit)
            st_nxt.rdata = st_r.strong_drive_select;
      end
      if (reg_wr && strong_hit)
      begin
         st_nxt.strong_drive_select = reg_wdata;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_r.rdata               <= PORT_DATA_RST;
         st_r.strong_drive_select <= HIGH_DRIVE_ENABLE_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata = st_r.rdata;

   // ************************************************************
   // strong drive
   // ************************************************************
   // pin_oe already folds in the output enable and analog use, so an
   // input or analog pin never gets strong drive
   assign strong_pin_out = {pin_oe[LANE_H][1], pin_oe[LANE_H][0],
                            pin_oe[LANE_E][1], pin_oe[LANE_E][0],
                            pin_oe[LANE_D][1], pin_oe[LANE_D][0],
                            pin_oe[LANE_B][5], pin_oe[LANE_B][4]};
   assign strong_drive_on = st_r.strong_drive_select & strong_pin_out;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   chk_read_one_cycle: assert property (
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside the answer cycle");

   chk_port_read_value: assert property (
      reg_rd && port_hit |=> reg_rdata == $past(lane_rd[lane_sel]))
      else $error("port read returns the wrong lane");

   chk_port_g_reserved: assert property (
      reg_rd && reg_addr == PORT_G_DATA_OFS |=> reg_rdata[7:4] == 4'h0)
      else $error("port g reserved bits read nonzero");

   chk_port_h_reserved: assert property (
      reg_rd && reg_addr == PORT_H_DATA_OFS |=> reg_rdata[5:3] == 3'h0)
      else $error("port h reserved bits read nonzero");

   chk_both_enables_latch: assert property (
      reg_wr && reg_addr == PORT_B_DATA_OFS
      ##1 reg_rd && reg_addr == PORT_B_DATA_OFS
          && pin_output_enable[LANE_B] == 8'hFF
          && pin_input_enable[LANE_B] == 8'hFF
          && analog_enable[LANE_B] == 8'h00
      |=> reg_rdata == $past(reg_wdata, 2))
      else $error("both enables set but pin level returned");

   chk_reset_clears: assert property (
      $fell(sys_rst) |-> pin_oe == '0 || pin_output_enable != '0)
      else $error("pin driven after reset with no output enable");

   chk_strong_readback: assert property (
      reg_wr && strong_hit ##1 reg_rd && strong_hit
      |=> reg_rdata == $past(reg_wdata, 2))
      else $error("strong drive register read back wrong");

   chk_strong_map_h1: assert property (
      strong_drive_on[7] |-> st_r.strong_drive_select[7]
                             && pin_output_enable[LANE_H][1])
      else $error("strong drive bit 7 not tied to port h pin 1");

   chk_strong_map_b4: assert property (
      strong_drive_on[0] |-> st_r.strong_drive_select[0]
                             && pin_output_enable[LANE_B][4])
      else $error("strong drive bit 0 not tied to port b pin 4");

   chk_strong_off_zero: assert property (
      reg_wr && strong_hit && reg_wdata == 8'h00
      |=> strong_drive_on == 8'h00)
      else $error("strong drive on after enable cleared");

   chk_strong_on_output: assert property (
      reg_wr && strong_hit && reg_wdata == 8'hFF
      ##1 strong_pin_out == 8'hFF |-> strong_drive_on == 8'hFF)
      else $error("strong drive off though enabled and output");

   chk_strong_input_off: assert property (
      (strong_drive_on & ~strong_pin_out) == 8'h00)
      else $error("strong drive active on a non-output pin");

   chk_reserved_g_write: assert property (
      reg_wr && reg_addr == PORT_G_DATA_OFS
      |=> (pin_out[LANE_G] & ~PORT_G_BITS) == 8'h00)
      else $error("port g reserved write stored");

   chk_analog_port_read: assert property (
      reg_rd && port_hit |=> (reg_rdata & $past(analog_enable[lane_sel])) == 8'h00)
      else $error("analog pin read nonzero");

   cov_write_read_port: cover property (
      reg_wr && port_hit ##1 reg_rd && port_hit);
   cov_input_read: cover property (
      reg_rd && port_hit && pin_input_enable[lane_sel] != 8'h00
      && pin_output_enable[lane_sel] == 8'h00);
   cov_strong_active: cover property (
      strong_drive_on != 8'h00);
   cov_reserved_write: cover property (
      reg_wr && reg_addr == PORT_H_DATA_OFS && reg_wdata[5:3] != 3'h0);

endmodule // port_data_regs
`default_nettype wire

/* File: hw/port_data_pkg.sv */
// constants shared by the port data and strong drive logic
`default_nettype none
package port_data_pkg;

   // ************************************************************
   // register offsets, printed byte addresses
   // ************************************************************
   localparam int             ADDR_W                 = 16;
   localparam logic [15:0]    PORT_B_DATA_OFS        = 16'h0001;
   localparam logic [15:0]    PORT_C_DATA_OFS        = 16'h0002;
   localparam logic [15:0]    PORT_D_DATA_OFS        = 16'h0003;
   localparam logic [15:0]    PORT_E_DATA_OFS        = 16'h0004;
   localparam logic [15:0]    PORT_F_DATA_OFS        = 16'h0005;
   localparam logic [15:0]    PORT_G_DATA_OFS        = 16'h0006;
   localparam logic [15:0]    PORT_H_DATA_OFS        = 16'h0007;
   localparam logic [15:0]    HIGH_DRIVE_ENABLE_OFS  = 16'h30AF;

   // ************************************************************
   // reset values and implemented data bits per port
   // ************************************************************
   localparam logic [7:0]     PORT_DATA_RST          = 8'h00;
   localparam logic [7:0]     HIGH_DRIVE_ENABLE_RST  = 8'h00;
   localparam int             NUM_PORTS              = 7;
   localparam logic [7:0]     FULL_PORT_BITS         = 8'hFF;
   localparam logic [7:0]     PORT_G_BITS            = 8'h0F;
   localparam logic [7:0]     PORT_H_BITS            = 8'hC7;
   localparam logic [NUM_PORTS-1:0][7:0] PORT_BITS   =
      {PORT_H_BITS, PORT_G_BITS, FULL_PORT_BITS, FULL_PORT_BITS,
       FULL_PORT_BITS, FULL_PORT_BITS, FULL_PORT_BITS};

   // ************************************************************
   // lane index of ports b, d, e, g and h inside the pin arrays, and the synchroniser settle count
   // ************************************************************
   localparam int             LANE_B                 = 0;
   localparam int             LANE_D                 = 2;
   localparam int             LANE_E                 = 3;
   localparam int             LANE_G                 = 5;
   localparam int             LANE_H                 = 6;
   localparam int             SYNC_SETTLE            = 3;

endpackage
`default_nettype wire

/* File: hw/lane_if.sv */
// signals between the register decode and one port lane
`timescale 1ns/1ps
`default_nettype none
interface lane_if;
   logic       wr;
   logic [7:0] wdata;
   logic [7:0] oe;
   logic [7:0] ie;
   logic [7:0] ana;
   logic [7:0] pin_in;
   logic [7:0] pin_out;
   logic [7:0] pin_oe;
   logic [7:0] rd_value;

   modport lane (input wr, wdata, oe, ie, ana, pin_in,
                 output pin_out, pin_oe, rd_value);
   modport ctrl (output wr, wdata, oe, ie, ana, pin_in,
                 input pin_out, pin_oe, rd_value);
endinterface
`default_nettype wire

/* File: hw/port_lane.sv */
// one port: data latch, pin synchroniser and read value selection
`timescale 1ns/1ps
`default_nettype none
module port_lane
   import port_data_pkg::*;
#(
   parameter logic [7:0] IMPL = FULL_PORT_BITS
)(
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   lane_if.lane      lane
);

   typedef struct packed {
      logic [7:0] data;
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [1:0] up;
   } lane_state_t;

   lane_state_t st_r;
   lane_state_t st_nxt;
   logic [7:0]  in_mode;
   logic [7:0]  out_mode;

   // ************************************************************
   // state
   // ************************************************************
   always_comb
   begin
      st_nxt.sync1 = lane.pin_in;
      st_nxt.sync2 = st_r.sync1;
      st_nxt.up    = (st_r.up == 2'(SYNC_SETTLE)) ? st_r.up : st_r.up + 2'h1;
      st_nxt.data  = st_r.data;
      if (lane.wr)
      begin
         // reserved positions never store, so they never drive
         st_nxt.data = lane.wdata & IMPL;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   // ************************************************************
   // pins and read value
   // ************************************************************
   // analog use takes the pin away from the digital driver
   assign out_mode      = lane.oe & ~lane.ana & IMPL;
   assign in_mode       = lane.ie & ~lane.oe & ~lane.ana & IMPL;
   assign lane.pin_out  = st_r.data;
   assign lane.pin_oe   = out_mode;
   // hi-z bits return the latch: cheap and deterministic
   assign lane.rd_value = ((st_r.data & ~in_mode) | (st_r.sync2 & in_mode))
                          & ~lane.ana & IMPL;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   chk_input_reads_pin: assert property (
      st_r.up == 2'(SYNC_SETTLE) |-> ((lane.rd_value ^ $past(lane.pin_in, 2)) & in_mode) == 8'h00)
      else $error("input bit does not read the pin level");
   chk_output_reads_latch: assert property (
      lane.wr ##1 (lane.oe == IMPL && lane.ana == 8'h00)
         |-> lane.rd_value == ($past(lane.wdata) & IMPL))
      else $error("output bit does not read the written value");
   chk_write_drives_pin: assert property (
      lane.wr |=> lane.pin_out == ($past(lane.wdata) & IMPL))
      else $error("write not latched onto the pin data");
   chk_analog_reads_zero: assert property (
      (lane.rd_value & lane.ana) == 8'h00)
      else $error("analog bit reads nonzero");
   chk_reserved_untouched: assert property (
      ((lane.pin_out | lane.pin_oe | lane.rd_value) & ~IMPL) == 8'h00)
      else $error("reserved bit stored or driven");

endmodule // port_lane
`default_nettype wire

/* File: tb/pin_world.sv */
// model of the circuitry outside the port pins
`timescale 1ns/1ps
`default_nettype none
module pin_world
   import port_data_pkg::*;
(
   input  wire logic [NUM_PORTS-1:0][7:0] pin_out,
   input  wire logic [NUM_PORTS-1:0][7:0] pin_oe,
   input  wire logic [NUM_PORTS-1:0][7:0] ext_level,
   output var  logic [NUM_PORTS-1:0][7:0] pin_in
);
   // ************************************************************
   // wire level
   // ************************************************************
   // an undriven pin shows what the outside circuit forces, which the
   // bench changes every test step, so a stale latch value cannot pass
   always_comb
      pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule // pin_world
`default_nettype wire

/* File: tb/tb_port_data_regs.sv */
// self-checking bench for the port data and strong drive registers
`timescale 1ns/1ps
`default_nettype none
module tb_port_data_regs
   import port_data_pkg::*;
;
   logic                      ref_clk, sys_rst, reg_wr, reg_rd, rd_d;
   logic [ADDR_W-1:0]         reg_addr;
   logic [7:0]                reg_wdata, reg_rdata, strong_drive_on, sd;
   logic [NUM_PORTS-1:0][7:0] oe, ie, ana, ext, pin_in, pin_out, pin_oe, lat, drv;
   logic [31:0]               seed;
   logic [7:0]                exp_q[$];
   int                        failures, cmp_count, cycles, p;
   localparam logic [15:0]    OFS [8] = '{PORT_B_DATA_OFS, PORT_C_DATA_OFS, PORT_D_DATA_OFS,
      PORT_E_DATA_OFS, PORT_F_DATA_OFS, PORT_G_DATA_OFS, PORT_H_DATA_OFS, HIGH_DRIVE_ENABLE_OFS};

   port_data_regs i_port_data_regs (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .pin_output_enable(oe), .pin_input_enable(ie), .analog_enable(ana), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .strong_drive_on(strong_drive_on));
   pin_world i_pin_world (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [7:0] rb();
      repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      cmp_count++;
      if (got !== want)
      begin
         failures++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, want);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
   endtask
   // write then read the same register with no gap between the strobes
   task automatic wr_rd(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      exp_q.push_back(d);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      @(posedge ref_clk);
      reg_rd    <= 1'b0;
   endtask
   task automatic shake();
      @(posedge ref_clk);
      for (int i = 0; i < NUM_PORTS; i++)
      begin
         oe[i]  <= rb();
         ie[i]  <= rb();
         ana[i] <= rb() & rb();
         ext[i] <= rb();
      end
   endtask
   // enables are zero here, so nothing may reach the pins
   task automatic reset_check();
      @(negedge ref_clk);
      for (int i = 0; i < NUM_PORTS; i++)
      begin
         chk(pin_out[i], 8'h00);
         chk(pin_oe[i], 8'h00);
      end
      chk(strong_drive_on, 8'h00);
      // release on a rising edge like every other input
      @(posedge ref_clk);
      sys_rst <= 1'b0;
      lat = '0;
      for (int i = 0; i < 8; i++)
         rd(OFS[i], 8'h00);
      $display("test reset done");
   endtask
   task automatic final_report();
      $display("counts: %0d compares, %0d mismatches", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ************************************************************
   // clock, monitor, timeout and sequence
   // ************************************************************
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // read data stand only in the cycle after the read edge
   always @(posedge ref_clk)
      rd_d <= reg_rd;
   always @(negedge ref_clk)
      if (rd_d === 1'b1)
         chk(reg_rdata, exp_q.pop_front());
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 2000)
      begin
         failures++;
         final_report();
      end
   end
   initial
   begin
      seed = 32'h3BBA104E;
      {sys_rst, reg_wr, reg_rd, rd_d} = 4'h8;
      {reg_addr, reg_wdata} = '0;
      {oe, ie, ana, ext, lat} = '0;
      {failures, cmp_count, cycles} = '0;
      repeat (11) @(posedge ref_clk);
      reset_check();
      wr(16'h30B0, 8'hFF);
      rd(16'h30B0, 8'h00);
      repeat (40)
      begin
         shake();
         p = int'(rb()) % NUM_PORTS;
         sd = rb();
         lat[p] = sd & PORT_BITS[p];
         wr(OFS[p], sd);
         @(negedge ref_clk);
         chk(pin_out[p], lat[p]);
         chk(pin_oe[p], oe[p] & ~ana[p] & PORT_BITS[p]);
         repeat (2) @(posedge ref_clk);
         rd(OFS[p], ((lat[p] & (oe[p] | ~ie[p])) | (ext[p] & ie[p] & ~oe[p]))
            & ~ana[p] & PORT_BITS[p]);
      end
      $display("test pin data done");
      repeat (12)
      begin
         shake();
         sd = rb();
         wr(HIGH_DRIVE_ENABLE_OFS, sd);
         @(negedge ref_clk);
         drv = oe & ~ana;
         chk(strong_drive_on, sd & {drv[LANE_H][1:0], drv[LANE_E][1:0], drv[LANE_D][1:0],
            drv[LANE_B][5:4]});
         rd(HIGH_DRIVE_ENABLE_OFS, sd);
      end
      $display("test strong drive done");
      // every pin an output with input enabled too, strobes back to back
      @(posedge ref_clk);
      oe  <= '1;
      ie  <= '1;
      ana <= '0;
      wr_rd(HIGH_DRIVE_ENABLE_OFS, 8'hFF);
      @(negedge ref_clk);
      chk(strong_drive_on, 8'hFF);
      wr_rd(HIGH_DRIVE_ENABLE_OFS, 8'h00);
      @(negedge ref_clk);
      chk(strong_drive_on, 8'h00);
      sd = rb();
      wr_rd(PORT_B_DATA_OFS, sd);
      @(negedge ref_clk);
      chk(pin_out[LANE_B], sd);
      $display("test directed done");
      @(posedge ref_clk);
      {oe, ie, ana} <= '0;
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset_check();
      repeat (4) @(posedge ref_clk);
      final_report();
   end
endmodule // tb_port_data_regs
`default_nettype wire
